// ---- verilog/ltmc_timer.sv ----
// Limit timer with mode control, scalers, interrupts and APB registers
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ltmc_timer (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic external_reset_signal_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [7:0] count_value_out,
  output logic period_event_pulse_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic run_q;
  logic [2:0] presc_sel_q;
  logic [3:0] post_sel_q;
  logic [3:0] mode_q;
  logic [7:0] count_q;
  logic [7:0] period_q;
  logic [2:0] int_st_q;
  logic [2:0] int_mask_q;
  logic [ltmc_pkg::PRESC_W-1:0] presc_q;
  logic rise_pend_q;
  logic fall_pend_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  ltmc_pkg::ltmc_os_e os_q;

  ltmc_pkg::ltmc_ers_s ers;
  ltmc_pkg::ltmc_ctl_s ctl;
  logic one_shot;
  logic [2:0] opt;
  logic lvl;
  logic rise;
  logic fall;
  logic tick;
  logic [ltmc_pkg::PRESC_W-1:0] presc_lim;
  logic [7:0] presc_full;
  logic counting;
  logic at_period;
  logic match;
  logic hw_rst_ev;
  logic os_done;
  logic scaler_clr;
  logic post_hit;
  logic access;
  logic xfer;
  logic wr;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_count;
  logic wr_period;
  logic wr_int_st;
  logic wr_int_mask;
  logic [2:0] int_set;
  logic [31:0] rd_data;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////////
  // External reset signal: synchronised, edges held until the next tick
  ltmc_ers_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .ers_in(external_reset_signal_in),
    .ers_out(ers)
  );

  // Edges seen while the run bit is clear are dropped, so a fresh edge
  // is needed after software sets it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rise_pend_q <= 1'b0;
      fall_pend_q <= 1'b0;
    end else if (ce_in) begin
      if (!run_q) begin
        rise_pend_q <= 1'b0;
        fall_pend_q <= 1'b0;
      end else begin
        rise_pend_q <= ers.rise | (rise_pend_q & ~tick);
        fall_pend_q <= ers.fall | (fall_pend_q & ~tick);
      end
    end
  end

  assign lvl = ers.level;
  assign rise = rise_pend_q;
  assign fall = fall_pend_q;
  assign one_shot = mode_q[ltmc_pkg::MODE_OS_BIT];
  assign opt = mode_q[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: tick marks one timer clock
  assign presc_full = (8'h01 << presc_sel_q) - 8'h01;
  assign presc_lim = presc_full[ltmc_pkg::PRESC_W-1:0];
  assign tick = (presc_q == presc_lim);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      presc_q <= '0;
    end else if (ce_in) begin
      if (scaler_clr || tick) begin
        presc_q <= '0;
      end else begin
        presc_q <= presc_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    ctl = '0;
    if (!one_shot) begin
      unique case (opt)
        ltmc_pkg::OPT_SW: ctl.gate = run_q;
        ltmc_pkg::OPT_HI: ctl.gate = run_q & lvl;
        ltmc_pkg::OPT_LO: ctl.gate = run_q & ~lvl;
        ltmc_pkg::OPT_ANY: begin
          ctl.gate = run_q;
          ctl.hw_rst = rise | fall;
        end
        ltmc_pkg::OPT_RISE: begin
          ctl.gate = run_q;
          ctl.hw_rst = rise;
        end
        ltmc_pkg::OPT_FALL: begin
          ctl.gate = run_q;
          ctl.hw_rst = fall;
        end
        ltmc_pkg::OPT_LVL_LO: begin
          ctl.gate = run_q & lvl;
          ctl.hw_rst = ~lvl;
        end
        ltmc_pkg::OPT_LVL_HI: begin
          ctl.gate = run_q & ~lvl;
          ctl.hw_rst = lvl;
        end
      endcase
    end else begin
      ctl.gate = run_q & (os_q == ltmc_pkg::OS_RUN);
      unique case (opt)
        ltmc_pkg::OPT_SW: ctl.start = run_q;
        ltmc_pkg::OPT_HI: ctl.start = run_q & rise;
        ltmc_pkg::OPT_LO: ctl.start = run_q & fall;
        ltmc_pkg::OPT_ANY: ctl.start = run_q & (rise | fall);
        ltmc_pkg::OPT_RISE: begin
          ctl.start = run_q & rise;
          ctl.hw_rst = rise;
        end
        ltmc_pkg::OPT_FALL: begin
          ctl.start = run_q & fall;
          ctl.hw_rst = fall;
        end
        ltmc_pkg::OPT_LVL_LO: begin
          ctl.start = run_q & rise;
          ctl.hw_rst = ~lvl;
        end
        ltmc_pkg::OPT_LVL_HI: begin
          ctl.start = run_q & fall;
          ctl.hw_rst = lvl;
        end
      endcase
    end
  end

  assign counting = tick & ctl.gate;
  assign at_period = (count_q == period_q);
  assign hw_rst_ev = tick & ctl.hw_rst;
  // A hardware reset in the same timer clock hides the match
  assign match = counting & at_period & ~ctl.hw_rst;
  assign os_done = match & one_shot;
  assign scaler_clr = wr_count | wr_ctrl | hw_rst_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a software write wins over the timer clock
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_q <= ltmc_pkg::COUNT_RST;
    end else if (ce_in) begin
      if (wr_count) begin
        count_q <= pwdata_in[7:0];
      end else if (hw_rst_ev) begin
        count_q <= ltmc_pkg::COUNT_RST;
      end else if (match) begin
        count_q <= ltmc_pkg::COUNT_RST;
      end else if (counting) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // One-shot sequencing
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      os_q <= ltmc_pkg::OS_WAIT;
    end else if (ce_in) begin
      unique case (os_q)
        ltmc_pkg::OS_WAIT: begin
          if (tick && one_shot && ctl.start) begin
            os_q <= ltmc_pkg::OS_RUN;
          end
        end
        ltmc_pkg::OS_RUN: begin
          if (!run_q || !one_shot || os_done) begin
            os_q <= ltmc_pkg::OS_WAIT;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler
  ltmc_postscaler u_post (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .clr_in(scaler_clr),
    .match_in(match),
    .sel_in(post_sel_q),
    .hit_out(post_hit),
    .pulse_out(period_event_pulse_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, writes land on the completing edge
  assign access = psel_in & penable_in & ~pready_q;
  assign xfer = psel_in & penable_in & pready_q;
  assign wr = xfer & pwrite_in & ~pslverr_q;
  assign wr_ctrl = wr & (paddr_in == ltmc_pkg::CTRL_OFS);
  assign wr_mode = wr & (paddr_in == ltmc_pkg::MODE_OFS);
  assign wr_count = wr & (paddr_in == ltmc_pkg::COUNT_OFS);
  assign wr_period = wr & (paddr_in == ltmc_pkg::PERIOD_OFS);
  assign wr_int_st = wr & (paddr_in == ltmc_pkg::INT_ST_OFS);
  assign wr_int_mask = wr & (paddr_in == ltmc_pkg::INT_MASK_OFS);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr_in)
      ltmc_pkg::CTRL_OFS: rd_data[7:0] = {run_q, presc_sel_q, post_sel_q};
      ltmc_pkg::MODE_OFS: rd_data[3:0] = mode_q;
      ltmc_pkg::COUNT_OFS: rd_data[7:0] = count_q;
      ltmc_pkg::PERIOD_OFS: rd_data[7:0] = period_q;
      ltmc_pkg::INT_ST_OFS: rd_data[2:0] = int_st_q;
      ltmc_pkg::INT_MASK_OFS: rd_data[2:0] = int_mask_q;
      ltmc_pkg::STATUS_OFS: rd_data[2:0] = {os_q == ltmc_pkg::OS_RUN, lvl,
                                            run_q};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_q <= access;
      pslverr_q <= access & rd_err;
      if (access && !pwrite_in) begin
        prdata_q <= rd_data;
      end else if (access) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mode and period registers
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
      presc_sel_q <= ltmc_pkg::PRESC_SEL_RST;
      post_sel_q <= ltmc_pkg::POST_SEL_RST;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        run_q <= pwdata_in[ltmc_pkg::CTRL_RUN_BIT];
        presc_sel_q <= pwdata_in[ltmc_pkg::CTRL_PRESC_LSB +: 3];
        post_sel_q <= pwdata_in[ltmc_pkg::CTRL_POST_LSB +: 4];
      end else if (os_done) begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mode_q <= ltmc_pkg::MODE_RST;
    end else if (ce_in && wr_mode) begin
      mode_q <= pwdata_in[3:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      period_q <= ltmc_pkg::PERIOD_RST;
    end else if (ce_in && wr_period) begin
      period_q <= pwdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set beats clear
  always_comb begin
    int_set = '0;
    int_set[ltmc_pkg::INT_PERIOD_BIT] = post_hit;
    int_set[ltmc_pkg::INT_ERS_BIT] = hw_rst_ev;
    int_set[ltmc_pkg::INT_DONE_BIT] = os_done;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      int_st_q <= ltmc_pkg::INT_RST;
      int_mask_q <= ltmc_pkg::INT_RST;
    end else if (ce_in) begin
      if (wr_int_st) begin
        int_st_q <= (int_st_q & ~pwdata_in[2:0]) | int_set;
      end else begin
        int_st_q <= int_st_q | int_set;
      end
      if (wr_int_mask) begin
        int_mask_q <= pwdata_in[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else if (ce_in) begin
      irq_q <= |(int_st_q & int_mask_q);
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign count_value_out = count_q;
  assign irq_out = irq_q;

endmodule // ltmc_timer
`default_nettype wire

// ---- verilog/ltmc_pkg.sv ----
// Constants, register map and carrier types of the limit timer mode control
//
// Function
// - Software gate: count while run bit set
// - Free-running match wraps counter to zero next clock
// - Modes 001/010 gate count on external level
// - Mode 011 clears counter on either edge
// - Modes 100/101 clear on rising/falling edge
// - Modes 110/111 hold reset on low/high level
// - One-shot 1000 starts on run bit set
// - One-shot end clears run bit, counter zero
// - One-shot 001/010/011 start on selected edge
// - One-shot 100/101 edge starts and resets counter
// - One-shot 110/111 edge start, level reset
// - After run set, fresh edge needed to restart
// - Postscaler match emits one-clock period event pulse
// - Reset clears counter, period all ones, scalers
package ltmc_pkg;

  localparam int unsigned CNT_W = 8;
  localparam int unsigned PRESC_W = 7;
  localparam int unsigned POST_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned INT_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] PERIOD_OFS = 8'h0c;
  localparam logic [7:0] INT_ST_OFS = 8'h10;
  localparam logic [7:0] INT_MASK_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_RUN_BIT = 7;
  localparam int unsigned CTRL_PRESC_LSB = 4;
  localparam int unsigned CTRL_POST_LSB = 0;

  // Mode field: bit 3 picks one-shot, low bits pick the control option
  localparam int unsigned MODE_OS_BIT = 3;
  localparam logic [2:0] OPT_SW = 3'h0;
  localparam logic [2:0] OPT_HI = 3'h1;
  localparam logic [2:0] OPT_LO = 3'h2;
  localparam logic [2:0] OPT_ANY = 3'h3;
  localparam logic [2:0] OPT_RISE = 3'h4;
  localparam logic [2:0] OPT_FALL = 3'h5;
  localparam logic [2:0] OPT_LVL_LO = 3'h6;
  localparam logic [2:0] OPT_LVL_HI = 3'h7;

  // Interrupt status bits
  localparam int unsigned INT_PERIOD_BIT = 0;
  localparam int unsigned INT_ERS_BIT = 1;
  localparam int unsigned INT_DONE_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] PRESC_SEL_RST = 3'h0;
  localparam logic [3:0] POST_SEL_RST = 4'h0;
  localparam logic [2:0] INT_RST = 3'h0;

  typedef enum logic {OS_WAIT, OS_RUN} ltmc_os_e;

  // Synchronised external reset signal and its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ltmc_ers_s;

  // Mode decode result for one timer clock
  typedef struct packed {
    logic gate;
    logic hw_rst;
    logic start;
  } ltmc_ctl_s;

endpackage

// ---- verilog/ltmc_ers_sync.sv ----
// Pin synchroniser and edge detector for the external reset signal
`timescale 1ns/10ps
`default_nettype none
module ltmc_ers_sync (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic ers_in,
  output ltmc_pkg::ltmc_ers_s ers_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic prev_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_in) begin
      s1_q <= ers_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two later stages agree
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      prev_q <= lvl_q;
    end
  end

  always_comb begin
    ers_out.level = lvl_q;
    ers_out.rise = lvl_q & ~prev_q;
    ers_out.fall = ~lvl_q & prev_q;
  end
endmodule // ltmc_ers_sync
`default_nettype wire

// ---- verilog/ltmc_postscaler.sv ----
// Output postscaler producing the period event pulse
`timescale 1ns/10ps
`default_nettype none
module ltmc_postscaler (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic clr_in,
  input wire logic match_in,
  input wire logic [3:0] sel_in,
  output logic hit_out,
  output logic pulse_out
);
  logic [ltmc_pkg::POST_W-1:0] cnt_q;
  logic hit;

  assign hit = match_in && (cnt_q == sel_in);
  assign hit_out = hit;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else if (ce_in) begin
      if (clr_in || hit) begin
        cnt_q <= '0;
      end else if (match_in) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Pulse lasts one whole timer clock: set on the hit, dropped next tick
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pulse_out <= 1'b0;
    end else if (ce_in && tick_in) begin
      pulse_out <= hit;
    end
  end
endmodule // ltmc_postscaler
`default_nettype wire

// ---- test/ltmc_ers_src.sv ----
// External reset source model driving the timer's reset pin
`timescale 1ns/10ps
`default_nettype none
module ltmc_ers_src (
  input wire logic clk_in,
  output logic ers_out
);
  // Every change is held eight clocks, so edges stay apart and levels
  // last long enough to pass the pin synchroniser
  task automatic drive(input logic lvl);
    @(posedge clk_in);
    ers_out <= lvl;
    repeat (8) @(posedge clk_in);
  endtask
  initial ers_out = 1'b0;
endmodule // ltmc_ers_src
`default_nettype wire

// ---- test/ltmc_timer_chk.sv ----
// Port assertions for the limit timer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module ltmc_timer_chk (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [7:0] count_value_out,
  input wire logic period_event_pulse_out,
  input wire logic irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  logic wr_done;
  logic wr_cnt;
  logic wr_irq;
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
  assign wr_cnt = wr_done && paddr_in == ltmc_pkg::COUNT_OFS;
  // Only status or mask writes may drop the interrupt line
  assign wr_irq = wr_done && (paddr_in == ltmc_pkg::INT_ST_OFS ||
    paddr_in == ltmc_pkg::INT_MASK_OFS);
  ////////////////////////////////////////
  a_reset_clears: assert property (disable iff (1'b0)
    reset_in && ce_in |=> count_value_out == 8'h00 && !irq_out &&
    !period_event_pulse_out) else $error("reset left outputs set");
  a_count_step: assert property (!$stable(count_value_out) |->
    count_value_out == $past(count_value_out) + 8'h01 ||
    count_value_out == 8'h00 || $past(wr_cnt))
    else $error("count jumped");
  a_count_write: assert property (wr_cnt |=>
    count_value_out == $past(pwdata_in[7:0]))
    else $error("count write lost");
  a_irq_fall: assert property ($fell(irq_out) && !$past(reset_in) |->
    $past(wr_irq, 2)) else $error("irq dropped by itself");
  a_pready_wait: assert property (psel_in && penable_in && !pready_out &&
    $past(psel_in && !penable_in) |=> pready_out)
    else $error("no answer after one wait state");
  a_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready_out && paddr_in[1:0] == 2'h0
    |-> pslverr_out == (paddr_in > ltmc_pkg::STATUS_OFS))
    else $error("error response wrong");
  a_write_rdata: assert property (pready_out && pwrite_in |->
    prdata_out == 32'h0) else $error("read data on write");
  c_pulse: cover property (period_event_pulse_out);
  c_irq: cover property (irq_out);
  c_err: cover property (pslverr_out);
endmodule // ltmc_timer_chk
bind ltmc_timer ltmc_timer_chk u_chk (.ref_clk_in, .reset_in, .ce_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .pready_out, .pslverr_out, .count_value_out, .period_event_pulse_out,
  .irq_out);
`default_nettype wire

// ---- test/tb_limit_timer_mode_control.sv ----
// Self-checking bench for the limit timer mode control
`timescale 1ns/10ps
`default_nettype none
module tb_limit_timer_mode_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [7:0] cnt;
  logic pulse;
  logic irq;
  logic ers;
  logic ce = 1'b1;
  logic nz = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  int npulse = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  ltmc_ers_src u_src (.clk_in(clk), .ers_out(ers));
  // Clock enable driven so a frozen stretch can be checked
  ltmc_timer u_dut (.ref_clk_in(clk), .reset_in(rst), .ce_in(ce),
    .external_reset_signal_in(ers), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .count_value_out(cnt), .period_event_pulse_out(pulse),
    .irq_out(irq));

  always @(posedge clk) begin
    cyc++;
    if (pulse === 1'b1) npulse++;
    if (cnt !== 8'h00) nz = 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      final_report;
    end
  end
  ////////////////////////////////////////
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // An idle cycle first, so psel never falls and rises in one step
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r[7:0], e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic go(input logic [3:0] m, input logic [7:0] p,
      input logic [7:0] k);
    wr(ltmc_pkg::MODE_OFS, {28'h0, m});
    wr(ltmc_pkg::PERIOD_OFS, {24'h0, p});
    wr(ltmc_pkg::COUNT_OFS, 32'h0);
    wr(ltmc_pkg::CTRL_OFS, {24'h0, k});
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rdc(ltmc_pkg::COUNT_OFS, 8'h00);
    rdc(ltmc_pkg::PERIOD_OFS, 8'hff);
    rdc(ltmc_pkg::CTRL_OFS, 8'h00);
    rdc(ltmc_pkg::MODE_OFS, 8'h00);
    rdc(ltmc_pkg::INT_MASK_OFS, 8'h00);
    rdc(8'h1c, 8'h00);
    chk({7'h0, last_err}, 8'h01);
  endtask
  task automatic t_free;
    logic [7:0] c;
    go(4'h0, 8'h03, 8'h81);
    while (cnt !== 8'h03) @(posedge clk);
    @(posedge clk);
    chk(cnt, 8'h00);
    @(posedge clk);
    chk(cnt, 8'h01);
    npulse = 0;
    tick(64);
    chk(npulse[7:0], 8'h08);
    wr(ltmc_pkg::CTRL_OFS, 32'h0);
    tick(1);
    c = cnt;
    tick(5);
    chk(cnt, c);
    rdc(ltmc_pkg::INT_ST_OFS, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(ltmc_pkg::INT_MASK_OFS, 32'h1);
    tick(2);
    chk({7'h0, irq}, 8'h01);
    wr(ltmc_pkg::INT_ST_OFS, 32'h1);
    tick(2);
    chk({7'h0, irq}, 8'h00);
  endtask
  task automatic t_gate;
    logic [7:0] c;
    for (int i = 1; i <= 2; i++) begin
      u_src.drive(i == 1);
      go(i[3:0], 8'hff, 8'h80);
      tick(1);
      c = cnt;
      tick(5);
      chk(cnt, c + 8'h05);
      u_src.drive(i != 1);
      c = cnt;
      tick(5);
      chk(cnt, c);
      wr(ltmc_pkg::CTRL_OFS, 32'h0);
    end
  endtask
  task automatic t_hw;
    for (int i = 3; i <= 5; i++) begin
      u_src.drive(i == 5);
      go(i[3:0], 8'hff, 8'h80);
      tick(20);
      u_src.drive(i != 5);
      chk({7'h0, cnt < 8'h0a}, 8'h01);
      tick(10);
      u_src.drive(i == 5);
      chk({7'h0, cnt < 8'h0a}, {7'h0, i == 3});
      wr(ltmc_pkg::CTRL_OFS, 32'h0);
    end
    rdc(ltmc_pkg::INT_ST_OFS, 8'h02);
    wr(ltmc_pkg::INT_ST_OFS, 32'h2);
  endtask
  task automatic t_level;
    logic [7:0] c;
    for (int i = 6; i <= 7; i++) begin
      u_src.drive(i == 7);
      go(i[3:0], 8'hff, 8'h80);
      // A nonzero start shows the level reset clearing, not just gating
      wr(ltmc_pkg::COUNT_OFS, 32'h40);
      tick(6);
      chk(cnt, 8'h00);
      u_src.drive(i == 6);
      c = cnt;
      tick(4);
      chk(cnt, c + 8'h04);
      wr(ltmc_pkg::CTRL_OFS, 32'h0);
    end
    wr(ltmc_pkg::INT_ST_OFS, 32'h7);
  endtask
  task automatic t_os_sw;
    logic [31:0] r;
    go(4'h8, 8'h03, 8'h80);
    nz = 1'b0;
    tick(20);
    chk({7'h0, nz}, 8'h01);
    rdc(ltmc_pkg::CTRL_OFS, 8'h00);
    chk(cnt, 8'h00);
    apb(1'b0, ltmc_pkg::INT_ST_OFS, 32'h0, r);
    chk({7'h0, r[2]}, 8'h01);
    wr(ltmc_pkg::INT_ST_OFS, 32'h7);
  endtask
  task automatic t_os_edge;
    logic p;
    for (int i = 9; i <= 15; i++) begin
      p = (i == 10 || i == 13 || i == 15);
      u_src.drive(p);
      // A qualifying edge while the run bit is clear must be ignored
      u_src.drive(!p);
      u_src.drive(p);
      go(i[3:0], 8'h05, 8'h80);
      nz = 1'b0;
      tick(10);
      chk({7'h0, nz}, 8'h00);
      u_src.drive(!p);
      tick(12);
      chk({7'h0, nz}, 8'h01);
      rdc(ltmc_pkg::CTRL_OFS, 8'h00);
      chk(cnt, 8'h00);
    end
  endtask
  // Prescale 1:2, a frozen stretch, then a reset in mid-run
  task automatic t_misc;
    logic [7:0] c;
    go(4'h0, 8'h80, 8'h90);
    tick(1);
    c = cnt;
    tick(8);
    chk(cnt, c + 8'h04);
    ce <= 1'b0;
    tick(1);
    c = cnt;
    tick(6);
    chk(cnt, c);
    ce <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    chk(cnt, 8'h00);
    rdc(ltmc_pkg::PERIOD_OFS, 8'hff);
    rdc(ltmc_pkg::CTRL_OFS, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_free;
    t_gate;
    t_hw;
    t_level;
    t_os_sw;
    t_os_edge;
    t_misc;
    final_report;
  end
endmodule // tb_limit_timer_mode_control
`default_nettype wire
